//--- hw/fle_lut_entry_compare.sv
/*
 * LUT entries 3 and 4 of the fan controller: limit and duty registers,
 * comparison against the remote diode reading and duty selection.
 * Assumes all inputs come from logic on clk (register decoder, temperature
 * converter, configuration bits) so none are synchronised here.
 */
`timescale 1ns/1ps

// Summary of operation
// - Low-res temp mode holds limit bit seven zero
// - High-res limit uses half bit, 0..127.5
// - Low-res limit spans 0..127 whole degrees
// - Compare nine reading bits high-res, eight low-res
// - Above entry 3 limit only, drive entry 3 duty
// - Above entry 4 limit, drive entry 4 duty
// - Limits are unsigned, bit seven never a sign bit
// - Offset register extends limits beyond 127 degrees
// - Low-res duty mode forces duty bits 7:6 zero
// - High-res duty joins extended and base bits
// - Extended duty bits need 22.5 kHz PWM
// - Low-res entry 3 uses duty bits 5:0
module fle_lut_entry_compare (
	input  wire logic                  clk,
	input  wire logic                  srst,
	input  wire fle_pkg::fle_reg_req_s reg_req,
	output logic [7:0]                 reg_rdata,
	output logic                       reg_rvalid,
	output logic                       reg_hit,
	input  wire logic                  lut_write_en,
	input  wire fle_pkg::fle_mode_s    mode,
	input  wire fle_pkg::fle_temp_s    remote_temp,
	input  wire logic [7:0]            lut_temp_offset,
	input  wire logic [7:0]            lower_duty,
	output logic [7:0]                 pwm_duty,
	output logic [1:0]                 entry_active
);

	logic [7:0] limit_reg [fle_pkg::N_ENTRIES];
	logic [7:0] duty_reg  [fle_pkg::N_ENTRIES];
	logic [7:0] limit_next [fle_pkg::N_ENTRIES];
	logic [7:0] duty_next  [fle_pkg::N_ENTRIES];
	logic [7:0] duty_eff  [fle_pkg::N_ENTRIES];
	logic [1:0] exceeds;
	logic [7:0] rdata_next;
	logic [7:0] pwm_duty_reg;
	logic [1:0] entry_active_reg;
	logic [7:0] reg_rdata_reg;
	logic       reg_rvalid_reg;
	logic       wr_ok;

	// Writes are dropped silently while the LUT is locked
	assign wr_ok = reg_req.wr & lut_write_en;

	////////////////////////////////////////////////////////////////////////////////
	// Per-entry registers and compare
	genvar gi;
	generate
		for (gi = 0; gi < fle_pkg::N_ENTRIES; gi++) begin : g_entry
			localparam logic [7:0] LIM_OFS = fle_pkg::LUT_ENTRY3_TEMP_LIMIT_OFS + 8'(2 * gi);
			localparam logic [7:0] DTY_OFS = fle_pkg::LUT_ENTRY3_DUTY_OFS + 8'(2 * gi);

			// Mask on write so mode bits that are unused read back zero
			always_comb begin
				limit_next[gi] = limit_reg[gi];
				duty_next[gi]  = duty_reg[gi];
				if (wr_ok && reg_req.addr == LIM_OFS) begin
					limit_next[gi] = {reg_req.wdata[7] & mode.temp_hires,
						reg_req.wdata[6:0]};
				end
				if (wr_ok && reg_req.addr == DTY_OFS) begin
					duty_next[gi] = {reg_req.wdata[7:6] & {2{mode.duty_hires}},
						reg_req.wdata[5:0]};
				end
			end

			// Limit and duty storage
			always_ff @(posedge clk) begin
				if (srst) begin
					limit_reg[gi] <= fle_pkg::LIMIT_RESET;
					duty_reg[gi]  <= fle_pkg::DUTY_RESET;
				end else begin
					limit_reg[gi] <= limit_next[gi];
					duty_reg[gi]  <= duty_next[gi];
				end
			end

			fle_entry u_entry (
				.limit_reg   (limit_reg[gi]),
				.duty_reg    (duty_reg[gi]),
				.temp_offset (lut_temp_offset),
				.temp        (remote_temp),
				.mode        (mode),
				.exceeds     (exceeds[gi]),
				.duty_eff    (duty_eff[gi])
			);
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////////
	// Read path: mode masks applied again so a mode change reads back at once
	always_comb begin
		rdata_next = fle_pkg::RDATA_RESET;
		reg_hit    = 1'b1;
		case (reg_req.addr)
			fle_pkg::LUT_ENTRY3_TEMP_LIMIT_OFS: rdata_next = {limit_reg[0][7] & mode.temp_hires,
				limit_reg[0][6:0]};
			fle_pkg::LUT_ENTRY3_DUTY_OFS: rdata_next = {duty_reg[0][7:6] & {2{mode.duty_hires}},
				duty_reg[0][5:0]};
			fle_pkg::LUT_ENTRY4_TEMP_LIMIT_OFS: rdata_next = {limit_reg[1][7] & mode.temp_hires,
				limit_reg[1][6:0]};
			fle_pkg::LUT_ENTRY4_DUTY_OFS: rdata_next = {duty_reg[1][7:6] & {2{mode.duty_hires}},
				duty_reg[1][5:0]};
			default: reg_hit = 1'b0; // Unmapped: read zero, no hit
		endcase
	end

	// Read data registered one cycle after the read strobe
	always_ff @(posedge clk) begin
		if (srst) begin
			reg_rdata_reg  <= fle_pkg::RDATA_RESET;
			reg_rvalid_reg <= 1'b0;
		end else begin
			reg_rvalid_reg <= reg_req.rd;
			if (reg_req.rd) begin
				reg_rdata_reg <= rdata_next;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Duty selection: the higher entry wins, else pass the lower entries' duty
	always_ff @(posedge clk) begin
		if (srst) begin
			pwm_duty_reg     <= fle_pkg::RDATA_RESET;
			entry_active_reg <= 2'b00;
		end else begin
			entry_active_reg <= exceeds;
			if (exceeds[1]) begin
				pwm_duty_reg <= duty_eff[1];
			end else if (exceeds[0]) begin
				pwm_duty_reg <= duty_eff[0];
			end else begin
				pwm_duty_reg <= lower_duty;
			end
		end
	end

	assign pwm_duty     = pwm_duty_reg;
	assign entry_active = entry_active_reg;
	assign reg_rdata    = reg_rdata_reg;
	assign reg_rvalid   = reg_rvalid_reg;

	////////////////////////////////////////////////////////////////////////////////
	// Assertions
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);

	a_entry4_drives: assert property (exceeds[1] |=> pwm_duty == $past(duty_eff[1]))
		else $error("entry 4 duty not driven");
	a_entry3_drives: assert property (exceeds == 2'b01 |=> pwm_duty == $past(duty_eff[0]))
		else $error("entry 3 duty not driven");
	a_lower_pass: assert property (exceeds == 2'b00 |=> pwm_duty == $past(lower_duty))
		else $error("lower duty not passed");
	a_write_locked: assert property (reg_req.wr && !lut_write_en |=>
		$stable(limit_reg[0]) && $stable(duty_reg[0]))
		else $error("write accepted while locked");
	a_write_taken: assert property (wr_ok && reg_req.addr == fle_pkg::LUT_ENTRY4_TEMP_LIMIT_OFS
		|=> limit_reg[1][6:0] == $past(reg_req.wdata[6:0]))
		else $error("entry 4 limit write lost");
	a_lores_half_zero: assert property (reg_req.rd && !mode.temp_hires &&
		reg_req.addr == fle_pkg::LUT_ENTRY3_TEMP_LIMIT_OFS |=> reg_rdata[7] == 1'b0)
		else $error("limit bit 7 reads one in low resolution");
	a_lores_duty_ext: assert property (wr_ok && !mode.duty_hires &&
		reg_req.addr == fle_pkg::LUT_ENTRY3_DUTY_OFS |=> duty_reg[0][7:6] == 2'b00)
		else $error("duty bits 7:6 stored in low resolution");
	a_ext_needs_22k5: assert property (!mode.pwm_22k5 |-> duty_eff[0][7:6] == 2'b00 &&
		duty_eff[1][7:6] == 2'b00)
		else $error("extended duty used without 22.5 kHz");
	a_hires_duty_full: assert property (mode.duty_hires && mode.pwm_22k5 |->
		duty_eff[0] == duty_reg[0])
		else $error("high resolution duty not concatenated");
	a_lores_cmp_whole: assert property (!mode.temp_hires && remote_temp.whole == 8'h00
		|-> !exceeds[0])
		else $error("zero reading exceeds a limit");
	a_rvalid_follows: assert property (reg_req.rd |=> reg_rvalid ##1 !reg_rvalid || $past(reg_req.rd))
		else $error("read valid timing wrong");

	// Reset clears outputs; own disable so the check runs while srst is high
	a_reset_clears: assert property (disable iff (1'b0) srst |=> pwm_duty == 8'h00 &&
		entry_active == 2'b00 && !reg_rvalid && reg_rdata == fle_pkg::RDATA_RESET)
		else $error("outputs not cleared by reset");

	// Read data stands until the next read strobe
	a_rdata_holds: assert property (!reg_req.rd |=> $stable(reg_rdata))
		else $error("read data changed without a read");

	// Hit flag covers exactly the four LUT offsets handled here
	a_hit_decode: assert property (reg_hit == (reg_req.addr >= fle_pkg::LUT_ENTRY3_TEMP_LIMIT_OFS
		&& reg_req.addr <= fle_pkg::LUT_ENTRY4_DUTY_OFS))
		else $error("register hit decode wrong");

	// Compare is strict: a reading equal to the half-degree limit is not above it
	a_hires_equal: assert property (mode.temp_hires && lut_temp_offset == 8'h00 &&
		remote_temp.whole == {1'b0, limit_reg[0][6:0]} &&
		remote_temp.half == limit_reg[0][fle_pkg::LIMIT_HALF_BIT] |-> !exceeds[0])
		else $error("reading equal to entry 3 limit counted as above");

	// Low resolution duty: only the six base bits reach the PWM value
	a_lores_duty_base: assert property (!mode.duty_hires |->
		duty_eff[0] == {2'b00, duty_reg[0][fle_pkg::DUTY_BASE_MSB:0]})
		else $error("entry 3 duty wider than six bits in low resolution");

	// Entry 4 duty reads back with bits 7:6 clear in low resolution
	a_lores_duty_read: assert property (reg_req.rd && !mode.duty_hires &&
		reg_req.addr == fle_pkg::LUT_ENTRY4_DUTY_OFS |=> reg_rdata[7:6] == 2'b00)
		else $error("entry 4 duty bits 7:6 read one in low resolution");

	// Main scenarios
	c_entry4_hot: cover property (exceeds == 2'b01 ##1 exceeds == 2'b11);
	c_hires_ext: cover property (exceeds[0] && mode.duty_hires && mode.pwm_22k5 &&
		duty_reg[0][7:6] != 2'b00);
	c_locked_write: cover property (reg_req.wr && !lut_write_en);
	c_offset_used: cover property (exceeds[1] && lut_temp_offset != 8'h00 &&
		remote_temp.whole > 8'h7f);

endmodule : fle_lut_entry_compare

//--- hw/fle_pkg.sv
/*
 * Shared constants and carrier types for the fan LUT entry 3/4 compare block.
 * Assumes the host serial interface decoder supplies a byte address and
 * write strobe, and that the fan controller core supplies mode bits.
 */
package fle_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// Register offsets on the host serial interface
	localparam logic [7:0] LUT_ENTRY3_TEMP_LIMIT_OFS = 8'h54;
	localparam logic [7:0] LUT_ENTRY3_DUTY_OFS       = 8'h55;
	localparam logic [7:0] LUT_ENTRY4_TEMP_LIMIT_OFS = 8'h56;
	localparam logic [7:0] LUT_ENTRY4_DUTY_OFS       = 8'h57;

	// Values after reset
	localparam logic [7:0] LIMIT_RESET = 8'h7f;
	localparam logic [7:0] DUTY_RESET  = 8'h3f;
	localparam logic [7:0] RDATA_RESET = 8'h00;

	// Field positions
	localparam int LIMIT_HALF_BIT = 7;
	localparam int DUTY_EXT_LSB   = 6;
	localparam int DUTY_EXT_MSB   = 7;
	localparam int DUTY_BASE_MSB  = 5;

	// Number of entries handled here and the first entry's index
	localparam int N_ENTRIES   = 2;
	localparam int FIRST_ENTRY = 3;

	////////////////////////////////////////////////////////////////////////////////
	// Carrier types
	typedef struct packed {
		logic temp_hires;  // Half-degree LUT limits in use
		logic duty_hires;  // Eight-bit LUT duty in use
		logic pwm_22k5;    // 22.5 kHz PWM frequency selected
	} fle_mode_s;

	typedef struct packed {
		logic [7:0] whole; // Remote temperature, whole degrees
		logic       half;  // Remote temperature, half-degree bit
	} fle_temp_s;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} fle_reg_req_s;

endpackage : fle_pkg

//--- hw/fle_entry.sv
/*
 * One LUT entry: effective limit, comparison against the remote reading and
 * the duty value that this entry offers. Purely combinational.
 * Assumes the stored registers were already masked on write.
 */
`timescale 1ns/1ps

module fle_entry (
	input  wire logic [7:0]        limit_reg,
	input  wire logic [7:0]        duty_reg,
	input  wire logic [7:0]        temp_offset,
	input  wire fle_pkg::fle_temp_s temp,
	input  wire fle_pkg::fle_mode_s mode,
	output logic                   exceeds,
	output logic [7:0]             duty_eff
);

	logic [8:0] eff_whole;
	logic       eff_half;

	////////////////////////////////////////////////////////////////////////////////
	// Limit is unsigned; offset extends it past 127 degrees
	assign eff_whole = {2'b00, limit_reg[6:0]} + {1'b0, temp_offset};
	// Half bit only counts in high resolution
	assign eff_half  = mode.temp_hires & limit_reg[fle_pkg::LIMIT_HALF_BIT];

	// Nine-bit reading against half-degree limit, else eight-bit whole degrees
	always_comb begin
		if (mode.temp_hires) begin
			exceeds = {1'b0, temp.whole, temp.half} > {eff_whole, eff_half};
		end else begin
			exceeds = {1'b0, temp.whole} > eff_whole;
		end
	end

	// Extended duty bits only with high resolution duty at 22.5 kHz
	always_comb begin
		if (mode.duty_hires && mode.pwm_22k5) begin
			duty_eff = duty_reg;
		end else begin
			duty_eff = {2'b00, duty_reg[fle_pkg::DUTY_BASE_MSB:0]};
		end
	end

endmodule : fle_entry

//--- verif/fle_lut_entry_compare_tb_top.sv
/*
 * Self-checking bench for the fan LUT entry 3/4 compare block: register
 * access, masking, compare thresholds, offset and duty selection.
 * Assumes the block's own access protocol and the package fle_pkg.
 */
`timescale 1ns/1ps

module fle_lut_entry_compare_tb_top;

	logic                  clk;
	logic                  srst;
	fle_pkg::fle_reg_req_s req;
	logic [7:0]            reg_rdata;
	logic                  reg_rvalid;
	logic                  reg_hit;
	logic                  lut_write_en;
	fle_pkg::fle_mode_s    mode;
	fle_pkg::fle_temp_s    temp;
	logic [7:0]            offset;
	logic [7:0]            lower;
	logic [7:0]            pwm_duty;
	logic [1:0]            entry_active;
	int                    n_fail;
	int                    n_tests;
	logic [7:0]            rst_exp [5] = '{8'h7f, 8'h3f, 8'h7f, 8'h3f, 8'h00};

	fle_lut_entry_compare i_fle_lut_entry_compare (
		.clk(clk), .srst(srst), .reg_req(req), .reg_rdata(reg_rdata),
		.reg_rvalid(reg_rvalid), .reg_hit(reg_hit), .lut_write_en(lut_write_en),
		.mode(mode), .remote_temp(temp), .lut_temp_offset(offset),
		.lower_duty(lower), .pwm_duty(pwm_duty), .entry_active(entry_active)
	);

	// 10 MHz clock
	always #50 clk = ~clk;

	////////////////////////////////////////////////////////////////////////////////
	// Verdict and comparison
	task automatic complete_run;
		if (n_fail == 0 && n_tests > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : complete_run

	task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp) begin
			n_fail++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : cmp

	////////////////////////////////////////////////////////////////////////////////
	// Register access: one-cycle strobes launched at the falling edge
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		req.addr  = a;
		req.wdata = d;
		req.wr    = 1'b1;
		@(negedge clk);
		req.wr    = 1'b0;
	endtask : wr

	// Bounded wait on the read answer so a dead strobe cannot hang the run
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		int n;
		n = 0;
		@(negedge clk);
		req.addr = a;
		req.rd   = 1'b1;
		@(negedge clk);
		cmp({7'h00, reg_hit}, (a >= 8'h54 && a <= 8'h57) ? 8'h01 : 8'h00);
		req.rd = 1'b0;
		while (reg_rvalid !== 1'b1 && n < 4) begin
			@(negedge clk);
			n++;
		end
		if (reg_rvalid !== 1'b1) begin
			n_fail++;
			complete_run();
		end
		cmp(reg_rdata, exp);
		// Valid stands one cycle only
		@(negedge clk);
		cmp({7'h00, reg_rvalid}, 8'h00);
	endtask : rd

	// Apply a reading, let the registered duty path settle, then check
	task automatic tchk(input logic [7:0] w, input logic h, input logic [7:0] d,
		input logic [1:0] act);
		@(negedge clk);
		temp.whole = w;
		temp.half  = h;
		repeat (2) @(negedge clk);
		cmp(pwm_duty, d);
		cmp({6'h00, entry_active}, {6'h00, act});
	endtask : tchk

	////////////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		clk = 1'b0; srst = 1'b1; req = '0; lut_write_en = 1'b0; mode = '0;
		temp = '0; offset = 8'h00; lower = 8'h11; n_fail = 0; n_tests = 0;
		repeat (3) @(negedge clk);
		cmp(pwm_duty, 8'h00);
		cmp({6'h00, entry_active}, 8'h00);
		cmp({7'h00, reg_rvalid}, 8'h00);
		srst = 1'b0;
		for (int i = 0; i < 5; i++) begin
			rd(8'h54 + 8'(i), rst_exp[i]);
		end
		wr(8'h54, 8'h00);
		rd(8'h54, 8'h7f);
		lut_write_en = 1'b1;
		wr(8'h56, 8'hff);
		rd(8'h56, 8'h7f);
		wr(8'h55, 8'hff);
		rd(8'h55, 8'h3f);
		wr(8'h54, 8'h28);
		wr(8'h56, 8'h32);
		wr(8'h55, 8'h05);
		wr(8'h57, 8'h2a);
		tchk(8'd30, 1'b0, 8'h11, 2'b00);
		tchk(8'd40, 1'b1, 8'h11, 2'b00);
		tchk(8'd41, 1'b0, 8'h05, 2'b01);
		tchk(8'd51, 1'b0, 8'h2a, 2'b11);
		// Half-degree limit of 40.5 only shows in high resolution
		mode.temp_hires = 1'b1;
		wr(8'h54, 8'ha8);
		rd(8'h54, 8'ha8);
		tchk(8'd40, 1'b1, 8'h11, 2'b00);
		tchk(8'd41, 1'b0, 8'h05, 2'b01);
		mode.temp_hires = 1'b0;
		rd(8'h54, 8'h28);
		offset = 8'd100;
		tchk(8'd140, 1'b0, 8'h11, 2'b00);
		tchk(8'd141, 1'b0, 8'h05, 2'b01);
		tchk(8'd200, 1'b1, 8'h2a, 2'b11);
		offset = 8'h00;
		// Extended duty bits need both high-res duty and 22.5 kHz
		mode.duty_hires = 1'b1;
		wr(8'h55, 8'hc5);
		tchk(8'd45, 1'b0, 8'h05, 2'b01);
		mode.pwm_22k5 = 1'b1;
		tchk(8'd46, 1'b0, 8'hc5, 2'b01);
		mode.duty_hires = 1'b0;
		tchk(8'd47, 1'b0, 8'h05, 2'b01);
		rd(8'h55, 8'h05);
		complete_run();
	end

endmodule : fle_lut_entry_compare_tb_top
